// File: spp_pkg.sv
package spp_pkg;

    // Register byte offsets on the bus.
    localparam logic [4:0] SPP_OFS_CTRL = 5'h00;
    localparam logic [4:0] SPP_OFS_CHAN = 5'h04;
    localparam logic [4:0] SPP_OFS_CMR = 5'h08;
    localparam logic [4:0] SPP_OFS_XPAD = 5'h0c;
    localparam logic [4:0] SPP_OFS_STAT = 5'h10;
    localparam logic [4:0] SPP_OFS_TS = 5'h14;
    localparam logic [4:0] SPP_OFS_LEN = 5'h18;

    // Control register field positions.
    localparam int SPP_CTRL_FULL_HEADER_EXCLUSIVE_SETTING = 0;
    localparam int SPP_CTRL_LEGACY = 1;
    localparam int SPP_CTRL_CMR_EN = 2;
    localparam int SPP_CTRL_STORAGE = 3;
    localparam int SPP_CTRL_PEER = 4;
    localparam int SPP_CTRL_FILE_GO = 5;

    // Values after reset, and the largest channel count.
    localparam logic [2:0] SPP_CHAN_RST = 3'h1;
    localparam logic [2:0] SPP_CHAN_MAX = 3'h4;
    localparam logic [7:0] SPP_CMR_RST = 8'hff;

    // Frame slots held for one packet or frame-block group.
    localparam int SPP_NFR = 8;
    localparam logic [3:0] SPP_NFR_MAX = 4'h8;

    // Counts of header bytes in the stored file.
    localparam logic [3:0] SPP_MAGIC_LEN = 4'h8;
    localparam logic [3:0] SPP_CHAN_LEN = 4'h4;

    // Frame type index codes (low four bits are the rate index) and legacy request codes.
    localparam logic [3:0] SPP_RATE_PRI_SID = 4'hc;
    localparam logic [3:0] SPP_RATE_LEG_SID = 4'h9;
    localparam logic [3:0] SPP_RATE_LOST = 4'he;
    localparam logic [3:0] SPP_RATE_NODATA = 4'hf;
    localparam logic [3:0] SPP_REQ_LEG_A = 4'h3;
    localparam logic [3:0] SPP_REQ_LEG_B = 4'h6;

    // Full-header legacy descriptor size that may match a compact size.
    localparam logic [11:0] SPP_SID_EXEMPT_LEN = 12'h007;

    // Protected compact payload sizes, in bytes.
    localparam int SPP_NPROT = 21;
    localparam logic [SPP_NPROT*12-1:0] SPP_PROT_LIST = {
        12'h007, 12'h012, 12'h014, 12'h018, 12'h021, 12'h029,
        12'h03d, 12'h050, 12'h078, 12'h0a0, 12'h0f0, 12'h140,
        12'h011, 12'h017, 12'h020, 12'h024, 12'h028, 12'h02e,
        12'h032, 12'h03a, 12'h03c};

    // Operating states of the packer.
    typedef enum logic [3:0] {
        SPP_COLLECT = 4'b0000,
        SPP_FILL = 4'b0001,
        SPP_DECIDE = 4'b0010,
        SPP_CMRB = 4'b0011,
        SPP_TOCB = 4'b0100,
        SPP_PADB = 4'b0101,
        SPP_XPADB = 4'b0110,
        SPP_MAGIC = 4'b0111,
        SPP_CHANB = 4'b1000
    } spp_state_t;

    // Whole state of the packer.
    typedef struct packed {
        spp_state_t st;
        logic [3:0] idx;
        logic [3:0] nfr;
        logic [1:0] ch;
        logic [SPP_NFR-1:0][5:0] ft;
        logic [11:0] sum;
        logic [31:0] ts;
        logic marker;
        logic [3:0] active;
        logic compact;
        logic [1:0] cpad;
        logic [7:0] xleft;
        logic [11:0] len;
        logic pflag;
        logic [7:0] obyte;
        logic ack;
        logic [31:0] rdat;
        logic full_header_exclusive_setting;
        logic legacy;
        logic cmr_en;
        logic storage;
        logic peer;
        logic [2:0] chans;
        logic [7:0] cmr;
        logic [7:0] xpad;
    } spp_regs_t;

endpackage

// File: spp_size_guard.sv
`timescale 1ns/1ps
// Finds the fewest zero bytes that move a length off every protected size.
module spp_size_guard
    import spp_pkg::*;
(
    input wire logic [11:0] len_i,
    input wire logic exempt_i,
    output logic [1:0] pad_o
);

    // True when the given length equals any protected size.
    function automatic logic is_protected(input logic [11:0] len);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < SPP_NPROT; i++) begin
            if (SPP_PROT_LIST[i*12 +: 12] == len) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Protected sizes are sparse, so two bytes always clear a collision.
    always_comb begin
        if (exempt_i || !is_protected(len_i)) begin
            pad_o = 2'h0;
        end else if (!is_protected(len_i + 12'h001)) begin
            pad_o = 2'h1;
        end else begin
            pad_o = 2'h2;
        end
    end

endmodule

// File: spp_packer.sv
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
module spp_packer
    import spp_pkg::*;
#(
    // File signature; this value is arbitrary.
    parameter logic [63:0] MAGIC_WORD = 64'h5350505f46494c45
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic frm_valid_i,
    output logic frm_ready_o,
    input wire logic [5:0] frame_type_index_i,
    input wire logic [11:0] frm_bits_i,
    input wire logic [31:0] frm_ts_i,
    input wire logic frm_lost_i,
    input wire logic frm_last_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [7:0] out_data_o,
    output logic marker_o,
    output logic padding_flag_o
);

    spp_regs_t s_q; // Registered state.
    spp_regs_t s_d; // Next state.
    logic accept; // A frame is taken this cycle.
    logic act; // The taken frame carries active speech.
    logic [5:0] ft_in; // Type index stored for the taken frame.
    logic [11:0] full_len; // Full-header length before padding.
    logic exempt; // Legacy descriptor payload that keeps 56 bits.
    logic [1:0] guard_pad; // Collision padding from the guard.
    logic single; // One mono frame in the packet.
    logic compact_ok; // Compact format is chosen.

    // Active speech is any rate below the descriptor code.
    function automatic logic is_active(input logic [5:0] ft);
        logic [3:0] silence_descriptor_frame;
        silence_descriptor_frame = ft[5] ? SPP_RATE_LEG_SID : SPP_RATE_PRI_SID;
        return ft[3:0] < silence_descriptor_frame;
    endfunction

    // Byte presented on the output for a given state.
    function automatic logic [7:0] emit_byte(input spp_regs_t n);
        logic f;
        logic [5:0] ft;
        f = (n.idx != n.nfr - 4'h1);
        ft = n.ft[n.idx[2:0]];
        emit_byte = 8'h00;
        unique case (n.st)
            SPP_CMRB: begin
                emit_byte = n.peer ? {n.cmr[3:0], 4'h0} : n.cmr;
            end
            SPP_TOCB: begin
                if (n.peer) begin
                    emit_byte = {f, ft[3:0], ft[4], 2'h0};
                end else begin
                    emit_byte = {1'b0, f, ft};
                end
            end
            SPP_XPADB: begin
                emit_byte = (n.xleft == 8'h01) ? n.xpad : 8'h00;
            end
            SPP_MAGIC: begin
                emit_byte = MAGIC_WORD[8'd63 - {n.idx, 3'h0} -: 8];
            end
            SPP_CHANB: begin
                // Channel count goes out most significant byte first.
                emit_byte = (n.idx == 4'h3) ? {5'h00, n.chans} : 8'h00;
            end
            SPP_COLLECT, SPP_FILL, SPP_DECIDE, SPP_PADB: begin
                emit_byte = 8'h00;
            end
        endcase
    endfunction

    // Collision padding decision for the full-header length.
    spp_size_guard u_guard (
        .len_i(full_len),
        .exempt_i(exempt),
        .pad_o(guard_pad)
    );

    // Frames are taken only while collecting.
    assign frm_ready_o = (s_q.st == SPP_COLLECT);
    assign accept = frm_valid_i && frm_ready_o;
    assign act = is_active(frame_type_index_i) && !frm_lost_i;
    // A lost frame is replaced by the lost code of its mode.
    assign ft_in = frm_lost_i ? {frame_type_index_i[5:4], SPP_RATE_LOST}
                              : frame_type_index_i;
    assign out_valid_o = (s_q.st == SPP_CMRB) || (s_q.st == SPP_TOCB) ||
                         (s_q.st == SPP_PADB) || (s_q.st == SPP_XPADB) ||
                         (s_q.st == SPP_MAGIC) || (s_q.st == SPP_CHANB);
    assign out_data_o = s_q.obyte;
    assign marker_o = s_q.marker;
    assign padding_flag_o = s_q.pflag;
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;

    // Header length is request byte (never stored), entries, then data.
    assign full_len = {11'h000, s_q.cmr_en & ~s_q.storage} +
                      {8'h00, s_q.nfr} + s_q.sum;
    // Legacy descriptor with one request byte and one entry stays at 56.
    assign exempt = s_q.legacy && s_q.cmr_en && (s_q.nfr == 4'h1) &&
                    (s_q.ft[0][3:0] == SPP_RATE_LEG_SID) &&
                    (full_len == SPP_SID_EXEMPT_LEN);
    assign single = (s_q.nfr == 4'h1) && (s_q.chans == 3'h1);
    // Compact only for the two single mono cases, never in exclusive mode.
    assign compact_ok = !s_q.full_header_exclusive_setting && !s_q.storage && !s_q.peer &&
        single && ((!s_q.ft[0][5] && !s_q.cmr_en) ||
        (s_q.ft[0][5] && s_q.cmr_en && (s_q.cmr[3:0] != SPP_REQ_LEG_A) &&
        (s_q.cmr[3:0] != SPP_REQ_LEG_B)));

    // Next-state logic for the bus slave, collector and byte emitter.
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        // Bus slave: answer one cycle after the request, once.
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.ack = 1'b1;
            s_d.rdat = 32'h00000000;
            if (wb_we_i && wb_sel_i[0]) begin
                unique case (wb_adr_i)
                    SPP_OFS_CTRL: begin
                        s_d.full_header_exclusive_setting = wb_dat_i[SPP_CTRL_FULL_HEADER_EXCLUSIVE_SETTING];
                        s_d.legacy = wb_dat_i[SPP_CTRL_LEGACY];
                        s_d.cmr_en = wb_dat_i[SPP_CTRL_CMR_EN];
                        s_d.storage = wb_dat_i[SPP_CTRL_STORAGE];
                        s_d.peer = wb_dat_i[SPP_CTRL_PEER];
                        // A file start is honoured only between packets.
                        if (wb_dat_i[SPP_CTRL_FILE_GO] &&
                            s_q.st == SPP_COLLECT && s_q.nfr == 4'h0) begin
                            s_d.st = SPP_MAGIC;
                            s_d.idx = 4'h0;
                        end
                    end
                    SPP_OFS_CHAN: begin
                        // Out-of-range counts fall back to mono.
                        if (wb_dat_i[2:0] == 3'h0 ||
                            wb_dat_i[2:0] > SPP_CHAN_MAX) begin
                            s_d.chans = SPP_CHAN_RST;
                        end else begin
                            s_d.chans = wb_dat_i[2:0];
                        end
                    end
                    SPP_OFS_CMR: s_d.cmr = wb_dat_i[7:0];
                    SPP_OFS_XPAD: s_d.xpad = wb_dat_i[7:0];
                    default: begin
                    end
                endcase
            end else if (!wb_we_i) begin
                unique case (wb_adr_i)
                    SPP_OFS_CTRL: s_d.rdat = {27'h0, s_q.peer, s_q.storage,
                        s_q.cmr_en, s_q.legacy, s_q.full_header_exclusive_setting};
                    SPP_OFS_CHAN: s_d.rdat = {29'h0, s_q.chans};
                    SPP_OFS_CMR: s_d.rdat = {24'h0, s_q.cmr};
                    SPP_OFS_XPAD: s_d.rdat = {24'h0, s_q.xpad};
                    SPP_OFS_STAT: s_d.rdat = {16'h0, 4'h0, s_q.nfr, 2'h0,
                        s_q.cpad, s_q.pflag, s_q.marker, s_q.compact,
                        (s_q.st != SPP_COLLECT)};
                    SPP_OFS_TS: s_d.rdat = s_q.ts;
                    SPP_OFS_LEN: s_d.rdat = {20'h0, s_q.len};
                    default: s_d.rdat = 32'h00000000;
                endcase
            end
        end
        unique case (s_q.st)
            SPP_COLLECT: begin
                if (accept) begin
                    s_d.ft[s_q.nfr[2:0]] = ft_in;
                    // Octet-aligned data size of each frame.
                    s_d.sum = s_q.sum + ((frm_bits_i + 12'h007) >> 3);
                    if (s_q.nfr == 4'h0) begin
                        s_d.ts = frm_ts_i;
                        s_d.marker = act && !s_q.active[s_q.ch];
                    end else if (act && !s_q.active[s_q.ch]) begin
                        s_d.marker = 1'b1;
                    end
                    s_d.active[s_q.ch] = act;
                    s_d.ch = ({1'b0, s_q.ch} == s_q.chans - 3'h1) ? 2'h0
                                                                  : s_q.ch + 2'h1;
                    s_d.nfr = s_q.nfr + 4'h1;
                    if (frm_last_i || s_q.nfr == SPP_NFR_MAX - 4'h1) begin
                        s_d.st = SPP_FILL;
                    end
                end
            end
            SPP_FILL: begin
                // Complete the last block with no-payload entries.
                if (s_q.ch != 2'h0 && s_q.nfr < SPP_NFR_MAX) begin
                    s_d.ft[s_q.nfr[2:0]] = {s_q.legacy, 1'b1,
                                            SPP_RATE_NODATA};
                    s_d.active[s_q.ch] = 1'b0;
                    s_d.ch = ({1'b0, s_q.ch} == s_q.chans - 3'h1) ? 2'h0
                                                                  : s_q.ch + 2'h1;
                    s_d.nfr = s_q.nfr + 4'h1;
                end else begin
                    s_d.st = SPP_DECIDE;
                end
            end
            SPP_DECIDE: begin
                s_d.idx = 4'h0;
                s_d.compact = compact_ok;
                // Collision padding only in default handling.
                s_d.cpad = (compact_ok || s_q.full_header_exclusive_setting || s_q.peer ||
                            s_q.storage) ? 2'h0 : guard_pad;
                s_d.xleft = s_q.storage ? 8'h00 : s_q.xpad;
                s_d.pflag = !s_q.storage && !compact_ok &&
                            (s_q.xpad != 8'h00);
                if (compact_ok) begin
                    s_d.len = s_q.sum;
                    s_d.st = SPP_COLLECT;
                    s_d.nfr = 4'h0;
                    s_d.ch = 2'h0;
                    s_d.sum = 12'h000;
                end else begin
                    s_d.len = full_len + {10'h000, s_d.cpad} +
                              {4'h0, s_d.xleft};
                    // Stored frames carry no request byte.
                    s_d.st = (s_q.cmr_en && !s_q.storage) ? SPP_CMRB
                                                          : SPP_TOCB;
                end
            end
            SPP_CMRB: begin
                if (out_ready_i) begin
                    s_d.st = SPP_TOCB;
                end
            end
            SPP_TOCB: begin
                if (out_ready_i) begin
                    if (s_q.idx == s_q.nfr - 4'h1) begin
                        s_d.idx = 4'h0;
                        if (s_q.cpad != 2'h0) begin
                            s_d.st = SPP_PADB;
                        end else if (s_q.xleft != 8'h00) begin
                            s_d.st = SPP_XPADB;
                        end else begin
                            s_d.st = SPP_COLLECT;
                        end
                    end else begin
                        s_d.idx = s_q.idx + 4'h1;
                    end
                end
            end
            SPP_PADB: begin
                if (out_ready_i) begin
                    s_d.cpad = s_q.cpad - 2'h1;
                    if (s_q.cpad == 2'h1) begin
                        s_d.st = (s_q.xleft != 8'h00) ? SPP_XPADB
                                                      : SPP_COLLECT;
                    end
                end
            end
            SPP_XPADB: begin
                if (out_ready_i) begin
                    s_d.xleft = s_q.xleft - 8'h01;
                    if (s_q.xleft == 8'h01) begin
                        s_d.st = SPP_COLLECT;
                    end
                end
            end
            SPP_MAGIC: begin
                if (out_ready_i) begin
                    s_d.idx = s_q.idx + 4'h1;
                    if (s_q.idx == SPP_MAGIC_LEN - 4'h1) begin
                        s_d.idx = 4'h0;
                        s_d.st = SPP_CHANB;
                    end
                end
            end
            SPP_CHANB: begin
                if (out_ready_i) begin
                    s_d.idx = s_q.idx + 4'h1;
                    if (s_q.idx == SPP_CHAN_LEN - 4'h1) begin
                        s_d.idx = 4'h0;
                        s_d.st = SPP_COLLECT;
                    end
                end
            end
            default: s_d.st = SPP_COLLECT;
        endcase
        // Leaving an emitting state clears the packet for the next one.
        if (s_q.st != SPP_COLLECT && s_q.st != SPP_DECIDE &&
            s_q.st != SPP_FILL && s_d.st == SPP_COLLECT) begin
            s_d.nfr = 4'h0;
            s_d.ch = 2'h0;
            s_d.sum = 12'h000;
        end
        s_d.obyte = emit_byte(s_d);
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.st <= SPP_COLLECT;
            s_q.chans <= SPP_CHAN_RST;
            s_q.cmr <= SPP_CMR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    AST_ACK_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held for two cycles");

    AST_HF_NO_COMPACT: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == SPP_DECIDE && s_q.full_header_exclusive_setting) |=> (!s_q.compact && s_q.cpad == 2'h0))
        else $error("compact or padding in exclusive full-header mode");

    AST_MULTI_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == SPP_DECIDE && s_q.chans > 3'h1) |=> !s_q.compact)
        else $error("multi-channel payload sent compact");

    AST_ENTRY_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == SPP_TOCB && !s_q.peer) |-> (!out_data_o[7] &&
        out_data_o[6] == (s_q.idx != s_q.nfr - 4'h1)))
        else $error("table entry byte has wrong header or follow bit");

    AST_ONSET_MARK: assert property (@(posedge clk_i) disable iff (rst_i)
        (accept && act && !s_q.active[s_q.ch]) |=> marker_o)
        else $error("onset frame did not set the marker");

    AST_TS_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
        (accept && s_q.nfr == 4'h0) |=> (s_q.ts == $past(frm_ts_i)))
        else $error("timestamp not taken from first frame");

    AST_FULL_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == SPP_DECIDE) |-> (s_q.ch == 2'h0 || s_q.nfr == SPP_NFR_MAX))
        else $error("frame-block left incomplete");

    AST_SID_NO_PAD: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == SPP_DECIDE && exempt) |=> s_q.cpad == 2'h0)
        else $error("legacy descriptor payload was padded");

    AST_MAGIC_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == SPP_MAGIC && s_q.idx == 4'h0) |-> out_data_o == MAGIC_WORD[63:56])
        else $error("file does not open with the signature");

endmodule

// File: spp_sink_model.sv
`timescale 1ns/1ps
// Byte sink in place of the remote decoder; stalls every other cycle while slow_i is set.
module spp_sink_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic out_valid_i,
    input wire logic [7:0] out_data_i,
    output logic out_ready_o
);
    logic [7:0] got[$]; // Header and pad bytes taken so far.
    // Take a byte on each valid and ready edge, toggling ready when slow.
    always @(posedge clk_i) begin
        if (rst_i) begin
            out_ready_o <= 1'b0;
        end else begin
            if (out_valid_i && out_ready_o) begin
                got.push_back(out_data_i);
            end
            out_ready_o <= slow_i ? ~out_ready_o : 1'b1;
        end
    end
endmodule

// File: speech_payload_packer_bench.sv
`timescale 1ns/1ps
// Register and frame level checks of the payload packer.
module speech_payload_packer_bench;
    import spp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, fv = 1'b0, fr, fla = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, fts = 32'h0, r;
    logic [5:0] ft = 6'h00;
    logic [11:0] fb = 12'h000;
    logic ov, ordy, mk, pf, slow = 1'b0;
    logic [7:0] od;
    int miscompares = 0;
    int num_checks = 0;
    logic fl = 1'b0;
    logic [3:0] sel = 4'hf;
    // Signature given to the packer; this value is arbitrary.
    localparam logic [63:0] SIG = 64'h0123456789abcdef;
    // Case table: control, type, bits, length, byte count, bytes.
    // Rows 3 and 5 are legacy descriptor frames; the last row is older-peer.
    logic [4:0] tc[6] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h06, 5'h16};
    logic [5:0] tf[6] = '{6'h04, 6'h04, 6'h04, 6'h39, 6'h22, 6'h39};
    logic [11:0] tbits[6] = '{12'h108, 12'h080, 12'h080, 12'h028, 12'h0fd,
        12'h028};
    logic [31:0] tl[6] = '{32'h21, 32'h13, 32'h12, 32'h07, 32'h22, 32'h07};
    int tn[6] = '{0, 3, 2, 2, 2, 2};
    logic [23:0] tb[6] = '{24'h0, 24'hb30400, 24'hb30400, 24'hb33900,
        24'hb32200, 24'h304c00};
    always #5 clk_i = ~clk_i;
    spp_packer #(.MAGIC_WORD(SIG)) u_spp_packer (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .frm_valid_i(fv),
        .frm_ready_o(fr), .frame_type_index_i(ft), .frm_bits_i(fb),
        .frm_ts_i(fts), .frm_lost_i(fl), .frm_last_i(fla),
        .out_valid_o(ov), .out_ready_i(ordy), .out_data_o(od),
        .marker_o(mk), .padding_flag_o(pf));
    spp_sink_model u_spp_sink_model (.clk_i(clk_i), .rst_i(rst_i),
        .slow_i(slow), .out_valid_i(ov), .out_data_i(od),
        .out_ready_o(ordy));
    // Print the counts and the verdict, then stop.
    task automatic close_out();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Compare one value and count it.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One classic bus cycle; read data lands in r at the ack edge.
    task automatic wb(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            close_out();
        end
        @(posedge clk_i);
    endtask
    // Offer one frame and hold it until taken.
    task automatic frm(input logic [5:0] t, input logic [11:0] b,
                       input logic [31:0] s, input logic last);
        int n;
        n = 0;
        fv <= 1'b1;
        ft <= t;
        fb <= b;
        fts <= s;
        fla <= last;
        do begin
            @(posedge clk_i);
            n++;
        end while (fr !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            close_out();
        end
        if (last) fv <= 1'b0;
    endtask
    // Poll status until the packer is idle again.
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, SPP_OFS_STAT, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            miscompares++;
            close_out();
        end
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, SPP_OFS_CHAN, 32'h0);
        chk(r, 32'h1);
        wb(1'b0, SPP_OFS_CMR, 32'h0);
        chk(r, 32'hff);
        // A write without the low byte lane is ignored.
        sel <= 4'he;
        wb(1'b1, SPP_OFS_CMR, 32'h11);
        sel <= 4'hf;
        wb(1'b0, SPP_OFS_CMR, 32'h0);
        chk(r, 32'hff);
        wb(1'b0, 5'h1c, 32'h0);
        chk(r, 32'h0);
        wb(1'b1, SPP_OFS_CHAN, 32'h5);
        wb(1'b0, SPP_OFS_CHAN, 32'h0);
        chk(r, 32'h1);
        // Two channels in one block, with the sink stalling.
        wb(1'b1, SPP_OFS_CHAN, 32'h2);
        slow <= 1'b1;
        frm(6'h04, 12'h108, 32'h100, 1'b0);
        frm(6'h02, 12'h108, 32'h200, 1'b1);
        wait_idle();
        chk(u_spp_sink_model.got.size(), 32'h2);
        chk(u_spp_sink_model.got[0], 32'h44);
        chk(u_spp_sink_model.got[1], 32'h02);
        chk(u_spp_sink_model.got[0][5:0], 32'h04);
        chk(u_spp_sink_model.got[1][5:0], 32'h02);
        chk(r[1], 1'b0);
        chk(mk, 1'b1);
        wb(1'b0, SPP_OFS_TS, 32'h0);
        chk(r, 32'h100);
        wb(1'b0, SPP_OFS_LEN, 32'h0);
        chk(r, 32'h44);
        // Single mono frames across the format and padding cases.
        wb(1'b1, SPP_OFS_CHAN, 32'h1);
        wb(1'b1, SPP_OFS_CMR, 32'hb3);
        for (int k = 0; k < 6; k++) begin
            u_spp_sink_model.got.delete();
            wb(1'b1, SPP_OFS_CTRL, {27'h0, tc[k]});
            frm(tf[k], tbits[k], 32'h0, 1'b1);
            wait_idle();
            chk(r[1], tn[k] == 0);
            chk(u_spp_sink_model.got.size(), tn[k]);
            for (int i = 0; i < tn[k]; i++)
                chk(u_spp_sink_model.got[i], tb[k][23-8*i -: 8]);
            wb(1'b0, SPP_OFS_LEN, 32'h0);
            chk(r, tl[k]);
        end
        chk(pf, 1'b0);
        // Extra padding: two bytes after one collision byte.
        u_spp_sink_model.got.delete();
        wb(1'b1, SPP_OFS_XPAD, 32'h2);
        wb(1'b1, SPP_OFS_CTRL, 32'h4);
        frm(6'h04, 12'h080, 32'h0, 1'b1);
        wait_idle();
        chk(u_spp_sink_model.got.size(), 32'h5);
        chk(u_spp_sink_model.got[4], 32'h02);
        chk(pf, 1'b1);
        wb(1'b0, SPP_OFS_LEN, 32'h0);
        chk(r, 32'h15);
        wb(1'b1, SPP_OFS_XPAD, 32'h0);
        // Legacy frame with a request that the compact field can carry.
        wb(1'b1, SPP_OFS_CMR, 32'h82);
        wb(1'b1, SPP_OFS_CTRL, 32'h6);
        frm(6'h22, 12'h0fd, 32'h0, 1'b1);
        wait_idle();
        chk(r[1], 1'b1);
        // Two channels share one request byte.
        wb(1'b1, SPP_OFS_CHAN, 32'h2);
        wb(1'b1, SPP_OFS_CTRL, 32'h4);
        u_spp_sink_model.got.delete();
        frm(6'h04, 12'h000, 32'h0, 1'b0);
        frm(6'h04, 12'h000, 32'h0, 1'b1);
        wait_idle();
        chk(u_spp_sink_model.got.size(), 32'h3);
        chk(u_spp_sink_model.got[0], 32'h82);
        // Stored file: header, then a lost frame and a filled slot.
        u_spp_sink_model.got.delete();
        wb(1'b1, SPP_OFS_CTRL, 32'h2c);
        wait_idle();
        fl <= 1'b1;
        frm(6'h04, 12'h000, 32'h0, 1'b1);
        fl <= 1'b0;
        wait_idle();
        for (int i = 0; i < 8; i++)
            chk(u_spp_sink_model.got[i], SIG[63-8*i -: 8]);
        chk(u_spp_sink_model.got[8], 32'h0);
        chk(u_spp_sink_model.got[11], 32'h2);
        chk(u_spp_sink_model.got.size(), 32'he);
        chk(u_spp_sink_model.got[12], 32'h4e);
        chk(u_spp_sink_model.got[13], 32'h1f);
        wb(1'b0, SPP_OFS_LEN, 32'h0);
        chk(r, 32'h2);
        close_out();
    end
endmodule
